// ==== core/instr_decode_pkg.sv ====
// Function
// - Opcode comes from instruction bits one to seven.
// - Bits eight to eleven select register operand.
// - Bits fifteen to thirty-one hold reference address.
// - Bits twelve to fourteen select index register.
// - Zero index field means no indexing, else add.
// - Bit zero set means memory word supplies address.
// - Indirection happens once, never chained further.
// - Opcode byte eighty or above is indirect form.
// - The no-memory class passes address field as control.
// - Immediate operand: no memory access, no indexing.
// - Immediate with bit zero set traps to forty.
// - Immediate twenty-bit field is sign-extended to 32.
// - Unmodified reference address is delivered when unmodified.
// - Indexed sum is effective address for reads, writes.
// - Indirect fetch first, then index is added.
package instr_decode_pkg;

  // ---------------------------------------------------------------
  // Field layout, LSB-numbered: word bit 0 (MSB) is index 31.
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int ADDR_W = 17;
  localparam int OPC_W = 7;
  localparam int REG_SEL_W = 4;
  localparam int IDX_SEL_W = 3;
  localparam int IMM_W = 20;
  localparam int IND_BIT = 31;
  localparam int OPC_HI = 30;
  localparam int OPC_LO = 24;
  localparam int REG_HI = 23;
  localparam int REG_LO = 20;
  localparam int IDX_HI = 19;
  localparam int IDX_LO = 17;
  localparam int ADDR_HI = 16;
  localparam int ADDR_LO = 0;
  localparam int IMM_HI = 19;
  localparam int IMM_LO = 0;
  localparam int IMM_SIGN = 19;

  // Trap vector for an indirect immediate instruction.
  localparam logic [ADDR_W-1:0] TRAP_ADDR = 17'h00040;
  localparam logic [IDX_SEL_W-1:0] NO_INDEX = 3'h0;

  // Instruction class, supplied by the opcode table upstream.
  typedef enum logic [1:0] {
    CLASS_MEMORY,
    CLASS_NO_MEMORY,
    CLASS_IMMEDIATE
  } instr_class_t;

endpackage

// ==== core/field_split.sv ====
`timescale 1ns/10ps
module field_split (
  input wire logic [31:0] word_i,
  output logic indirect_flag_o,
  output logic [6:0] opcode_o,
  output logic [3:0] reg_sel_o,
  output logic [2:0] idx_sel_o,
  output logic [16:0] ref_addr_o,
  output logic [31:0] imm_value_o
);

  // ---------------------------------------------------------------
  // Pure field extraction; the decoder registers the results.
  // ---------------------------------------------------------------
  assign indirect_flag_o = word_i[instr_decode_pkg::IND_BIT];
  assign opcode_o = word_i[instr_decode_pkg::OPC_HI:instr_decode_pkg::OPC_LO];
  assign reg_sel_o = word_i[instr_decode_pkg::REG_HI:instr_decode_pkg::REG_LO];
  assign idx_sel_o = word_i[instr_decode_pkg::IDX_HI:instr_decode_pkg::IDX_LO];
  assign ref_addr_o = word_i[instr_decode_pkg::ADDR_HI:instr_decode_pkg::ADDR_LO];

  // Sign bit replicated over the upper twelve bits.
  assign imm_value_o = {{(instr_decode_pkg::WORD_W - instr_decode_pkg::IMM_W)
                         {word_i[instr_decode_pkg::IMM_SIGN]}},
                        word_i[instr_decode_pkg::IMM_HI:instr_decode_pkg::IMM_LO]};

endmodule

// ==== core/instr_decode.sv ====
`timescale 1ns/10ps
module instr_decode (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Instruction request from fetch.
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_word_i,
  input wire instr_decode_pkg::instr_class_t instr_class_i,
  output logic instr_ready_o,
  // Index register read port.
  output logic [2:0] idx_rd_sel_o,
  input wire logic [31:0] idx_rd_data_i,
  // Indirect word fetch from memory.
  output logic ind_req_o,
  output logic [16:0] ind_addr_o,
  input wire logic ind_ack_i,
  input wire logic [31:0] ind_data_i,
  // Decoded result.
  output logic done_o,
  output logic [6:0] opcode_o,
  output logic [3:0] reg_sel_o,
  output logic mem_access_o,
  output logic [16:0] eff_addr_o,
  output logic [16:0] ctrl_info_o,
  output logic imm_valid_o,
  output logic [31:0] imm_value_o,
  output logic trap_o,
  output logic [16:0] trap_addr_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_IND_WAIT,
    ST_DONE
  } state_t;

  // ---------------------------------------------------------------
  // Field split of the incoming word.
  // ---------------------------------------------------------------
  logic f_ind;
  logic [6:0] f_opc;
  logic [3:0] f_reg;
  logic [2:0] f_idx;
  logic [16:0] f_addr;
  logic [31:0] f_imm;

  field_split u_split (
    .word_i(instr_word_i),
    .indirect_flag_o(f_ind),
    .opcode_o(f_opc),
    .reg_sel_o(f_reg),
    .idx_sel_o(f_idx),
    .ref_addr_o(f_addr),
    .imm_value_o(f_imm)
  );

  state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic [16:0] addr_reg, addr_next;
  logic [6:0] opc_reg, opc_next;
  logic [3:0] rsel_reg, rsel_next;
  logic mem_reg, mem_next;
  logic [16:0] ctrl_reg, ctrl_next;
  logic immv_reg, immv_next;
  logic [31:0] imm_reg, imm_next;
  logic trap_reg, trap_next;
  logic done_reg, done_next;
  logic take;
  logic [16:0] idx_add;
  logic [16:0] base_addr;

  assign take = instr_valid_i && (state_reg == ST_IDLE);
  assign instr_ready_o = (state_reg == ST_IDLE);
  assign ind_req_o = (state_reg == ST_IND_WAIT);
  assign ind_addr_o = addr_reg;

  // Index select is held while fetching the indirect word so the
  // register file sees a stable select; it reads combinationally.
  assign idx_rd_sel_o = (state_reg == ST_IDLE) ? f_idx : idx_reg;

  // Index contents, truncated to address width; zero when unindexed.
  always_comb begin
    if (((state_reg == ST_IDLE) ? f_idx : idx_reg) == instr_decode_pkg::NO_INDEX) begin
      idx_add = '0;
    end else begin
      idx_add = idx_rd_data_i[instr_decode_pkg::ADDR_W-1:0];
    end
  end

  // Only the low address bits of the pointer word count, and the
  // pointer's own top bit is ignored so indirection never chains.
  assign base_addr = ind_data_i[instr_decode_pkg::ADDR_W-1:0];

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    addr_next = addr_reg;
    opc_next = opc_reg;
    rsel_next = rsel_reg;
    mem_next = mem_reg;
    ctrl_next = ctrl_reg;
    immv_next = immv_reg;
    imm_next = imm_reg;
    trap_next = trap_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          opc_next = f_opc;
          rsel_next = f_reg;
          idx_next = f_idx;
          mem_next = 1'b0;
          ctrl_next = '0;
          immv_next = 1'b0;
          imm_next = '0;
          trap_next = 1'b0;
          addr_next = f_addr;
          case (instr_class_i)
            instr_decode_pkg::CLASS_IMMEDIATE: begin
              if (f_ind) begin
                trap_next = 1'b1;
                addr_next = instr_decode_pkg::TRAP_ADDR;
              end else begin
                immv_next = 1'b1;
                imm_next = f_imm;
              end
              state_next = ST_DONE;
            end
            instr_decode_pkg::CLASS_NO_MEMORY: begin
              ctrl_next = f_addr;
              state_next = ST_DONE;
            end
            default: begin
              if (f_ind) begin
                state_next = ST_IND_WAIT;
              end else begin
                mem_next = 1'b1;
                addr_next = 17'(f_addr + idx_add);
                state_next = ST_DONE;
              end
            end
          endcase
        end
      end
      ST_IND_WAIT: begin
        if (ind_ack_i) begin
          mem_next = 1'b1;
          addr_next = 17'(base_addr + idx_add);
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        done_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers; clock enable freezes everything.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= '0;
      addr_reg <= '0;
      opc_reg <= '0;
      rsel_reg <= '0;
      mem_reg <= 1'b0;
      ctrl_reg <= '0;
      immv_reg <= 1'b0;
      imm_reg <= '0;
      trap_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce_i) begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      addr_reg <= addr_next;
      opc_reg <= opc_next;
      rsel_reg <= rsel_next;
      mem_reg <= mem_next;
      ctrl_reg <= ctrl_next;
      immv_reg <= immv_next;
      imm_reg <= imm_next;
      trap_reg <= trap_next;
      done_reg <= done_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops.
  // ---------------------------------------------------------------
  assign done_o = done_reg;
  assign opcode_o = opc_reg;
  assign reg_sel_o = rsel_reg;
  assign mem_access_o = mem_reg;
  assign eff_addr_o = trap_reg ? '0 : addr_reg;
  assign ctrl_info_o = ctrl_reg;
  assign imm_valid_o = immv_reg;
  assign imm_value_o = imm_reg;
  assign trap_o = trap_reg;
  assign trap_addr_o = trap_reg ? addr_reg : '0;

  // ---------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  opcode_field_a: assert property (take && ce_i |=> opc_reg == $past(instr_word_i[30:24]))
    else $error("opcode not taken from bits 1 to 7");
  regsel_field_a: assert property (take && ce_i |=> rsel_reg == $past(instr_word_i[23:20]))
    else $error("register select wrong");
  direct_addr_a: assert property (take && ce_i && !f_ind && f_idx == 3'h0 &&
      instr_class_i == instr_decode_pkg::CLASS_MEMORY |=> addr_reg == $past(f_addr))
    else $error("direct unindexed address modified");
  indexed_addr_a: assert property (take && ce_i && !f_ind &&
      instr_class_i == instr_decode_pkg::CLASS_MEMORY |=>
      addr_reg == 17'($past(f_addr) + $past(idx_add)))
    else $error("indexed address wrong");
  ind_fetch_a: assert property (take && ce_i && f_ind &&
      instr_class_i == instr_decode_pkg::CLASS_MEMORY |=> ind_req_o && ind_addr_o == $past(f_addr))
    else $error("indirect fetch not issued at reference address");
  post_index_a: assert property (ind_req_o && ind_ack_i && ce_i |=>
      addr_reg == 17'($past(ind_data_i[16:0]) + $past(idx_add)) && !ind_req_o)
    else $error("post-index address wrong");
  imm_trap_a: assert property (take && ce_i && f_ind &&
      instr_class_i == instr_decode_pkg::CLASS_IMMEDIATE |=> trap_o && trap_addr_o == 17'h00040
      && !mem_access_o)
    else $error("indirect immediate did not trap");
  imm_sign_a: assert property (immv_reg |-> imm_reg[31:20] == {12{imm_reg[19]}} && !mem_reg)
    else $error("immediate not sign extended");
  ctrl_pass_a: assert property (take && ce_i && instr_class_i == instr_decode_pkg::CLASS_NO_MEMORY
      |=> ctrl_reg == $past(f_addr) && !mem_reg)
    else $error("control info not passed");
  done_pulse_a: assert property (done_o && ce_i |=> !done_o)
    else $error("done held more than one cycle");

  ind_cov_c: cover property (ind_req_o && ind_ack_i && idx_rd_sel_o != 3'h0);
  trap_cov_c: cover property (trap_o);
  imm_cov_c: cover property (imm_valid_o && imm_value_o[31]);
  ctrl_cov_c: cover property (take && instr_class_i == instr_decode_pkg::CLASS_NO_MEMORY);

endmodule

// ==== test/reg_mem_model.sv ====
`timescale 1ns/10ps
module reg_mem_model (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lat_i,
  input wire logic [2:0] idx_rd_sel_i,
  output logic [31:0] idx_rd_data_o,
  input wire logic ind_req_i,
  input wire logic [16:0] ind_addr_i,
  output logic ind_ack_o,
  output logic [31:0] ind_data_o
);
  logic [1:0] wait_reg;

  // --------------------------------------------------------------
  // Fixed contents
  // --------------------------------------------------------------
  // Register values carry high bits so that missing truncation to 17 bits shows.
  function automatic logic [31:0] reg_word(input logic [2:0] n);
    return 32'hF0000000 | (32'h00012345 * {29'h0, n});
  endfunction

  // Pointer words often have bit 31 set, which must not chain.
  function automatic logic [31:0] mem_word(input logic [16:0] a);
    return {~a[14:0], a};
  endfunction

  // The register file answers in the same cycle, as the decoder expects.
  assign idx_rd_data_o = reg_word(idx_rd_sel_i);
  // Outside the acknowledge cycle the data is inverted, so early sampling shows.
  assign ind_data_o = ind_ack_o ? mem_word(ind_addr_i) : ~mem_word(ind_addr_i);

  // Memory answers after lat_i extra cycles with a one-cycle acknowledge.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !ind_req_i || ind_ack_o) begin
      ind_ack_o <= 1'b0;
      wait_reg <= 2'h0;
    end else if (wait_reg == lat_i) begin
      ind_ack_o <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ==== test/instr_decode_tb.sv ====
`timescale 1ns/10ps
module instr_decode_tb;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_valid_i = 1'b0;
  logic [31:0] instr_word_i = 32'h00000000;
  instr_decode_pkg::instr_class_t instr_class_i = instr_decode_pkg::CLASS_MEMORY;
  logic [1:0] lat_reg = 2'h0;
  logic instr_ready_o, ind_req_o, ind_ack_i, done_o, mem_access_o, imm_valid_o, trap_o;
  logic [2:0] idx_rd_sel_o;
  logic [31:0] idx_rd_data_i, ind_data_i, imm_value_o, r;
  logic [16:0] ind_addr_o, eff_addr_o, ctrl_info_o, trap_addr_o;
  logic [6:0] opcode_o;
  logic [3:0] reg_sel_o;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  // Clock enable is tied high; freezing is outside what these tests probe.
  instr_decode i_instr_decode (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
    .instr_class_i(instr_class_i), .instr_ready_o(instr_ready_o),
    .idx_rd_sel_o(idx_rd_sel_o), .idx_rd_data_i(idx_rd_data_i), .ind_req_o(ind_req_o),
    .ind_addr_o(ind_addr_o), .ind_ack_i(ind_ack_i), .ind_data_i(ind_data_i),
    .done_o(done_o), .opcode_o(opcode_o), .reg_sel_o(reg_sel_o),
    .mem_access_o(mem_access_o), .eff_addr_o(eff_addr_o), .ctrl_info_o(ctrl_info_o),
    .imm_valid_o(imm_valid_o), .imm_value_o(imm_value_o), .trap_o(trap_o),
    .trap_addr_o(trap_addr_o));

  reg_mem_model i_reg_mem_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .lat_i(lat_reg),
    .idx_rd_sel_i(idx_rd_sel_o), .idx_rd_data_o(idx_rd_data_i), .ind_req_i(ind_req_o),
    .ind_addr_i(ind_addr_o), .ind_ack_o(ind_ack_i), .ind_data_o(ind_data_i));

  // --------------------------------------------------------------
  // Compare and report
  // --------------------------------------------------------------
  task automatic chk_w(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input string what, input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang counts against the run; 208 transfers need far fewer cycles.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // --------------------------------------------------------------
  // One decode: offer, wait for done, then compare the results its class defines
  // --------------------------------------------------------------
  task automatic run(input logic [31:0] w, input instr_decode_pkg::instr_class_t c,
                     input logic [1:0] lat);
    logic [31:0] ptr;
    logic [31:0] idx;
    logic [16:0] eff;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    instr_word_i <= w;
    instr_class_i <= c;
    lat_reg <= lat;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    for (int k = 0; k < 20; k++) begin
      @(negedge ref_clk_i);
      if (ind_req_o === 1'b1) chk_w("ind_addr", {15'h0, ind_addr_o}, {15'h0, w[16:0]});
      if (done_o === 1'b1) break;
    end
    chk_b("done", done_o, 1'b1);
    chk_w("opcode", {25'h0, opcode_o}, {25'h0, w[30:24]});
    chk_w("reg_sel", {28'h0, reg_sel_o}, {28'h0, w[23:20]});
    ptr = i_reg_mem_model.mem_word(w[16:0]);
    idx = (w[19:17] != 3'h0) ? i_reg_mem_model.reg_word(w[19:17]) : 32'h00000000;
    eff = (w[31] ? ptr[16:0] : w[16:0]) + idx[16:0];
    if (c == instr_decode_pkg::CLASS_IMMEDIATE) begin
      chk_b("trap", trap_o, w[31]);
      chk_b("imm_mem", mem_access_o, 1'b0);
      if (w[31]) chk_w("trap_addr", {15'h0, trap_addr_o}, 32'h00000040);
      else chk_w("imm", imm_value_o, {{12{w[19]}}, w[19:0]});
      if (!w[31]) chk_b("imm_valid", imm_valid_o, 1'b1);
    end else if (c == instr_decode_pkg::CLASS_NO_MEMORY) begin
      chk_b("nomem", mem_access_o, 1'b0);
      chk_w("ctrl", {15'h0, ctrl_info_o}, {15'h0, w[16:0]});
    end else begin
      chk_b("mem", mem_access_o, 1'b1);
      chk_w("eff", {15'h0, eff_addr_o}, {15'h0, eff});
    end
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    run(32'hB2B0103A, instr_decode_pkg::CLASS_MEMORY, 2'h0);
    run(32'h38CA0407, instr_decode_pkg::CLASS_MEMORY, 2'h0);
    run(32'hB59605B6, instr_decode_pkg::CLASS_MEMORY, 2'h3);
    run(32'h32B000A3, instr_decode_pkg::CLASS_MEMORY, 2'h1);
    run(32'hFFFFFFFF, instr_decode_pkg::CLASS_MEMORY, 2'h2);
    run(32'hA2300123, instr_decode_pkg::CLASS_IMMEDIATE, 2'h0);
    run(32'h221FFF2E, instr_decode_pkg::CLASS_IMMEDIATE, 2'h0);
    run(32'hA5012345, instr_decode_pkg::CLASS_NO_MEMORY, 2'h0);
    $display("test corner done");
    r = 32'h98533CD7;
    repeat (200) begin
      r = lfsr_next(r);
      run(r, instr_decode_pkg::instr_class_t'((r[9:8] == 2'h3) ? 2'h0 : r[9:8]), r[5:4]);
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
